// [inc/supervisor_regs.svh]
/*
  Timing and width constants of the reset supervisor.
  Assumes a 100 MHz core clock; every time is given in its own unit and the
  cycle or tick counts are derived from it.
*/
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

// ----------------------------------------------------------------------------
// clock and timebase
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define TICK_TIME_NS 1000000
`define TICK_TIME_MS 1
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define TICK_W 17
`define CNT_W 16

// ----------------------------------------------------------------------------
// reset hold and watchdog periods, counted in timebase ticks
// ----------------------------------------------------------------------------
`define HOLD_TIME_MS 200
`define HOLD_TICKS (`HOLD_TIME_MS / `TICK_TIME_MS)
`define HOLD_CAP_TIME_MS 250
`define HOLD_CAP_TICKS (`HOLD_CAP_TIME_MS / `TICK_TIME_MS)
`define WDT_TIME_MS 1600
`define WDT_TICKS (`WDT_TIME_MS / `TICK_TIME_MS)
`define WDT_START_TIME_MS 51000
`define WDT_START_TICKS (`WDT_START_TIME_MS / `TICK_TIME_MS)

// ----------------------------------------------------------------------------
// input qualification, in core clock cycles (least times round up)
// ----------------------------------------------------------------------------
`define MR_MIN_TIME_NS 1000
`define MR_MIN_CYCLES ((`MR_MIN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UV_ASSERT_CYCLES 1
`define UV_RELEASE_TIME_NS 1000
`define UV_RELEASE_CYCLES ((`UV_RELEASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QUAL_W 8

`endif

// [inc/supervisor_pkg.sv]
/*
  Types shared by the reset supervisor files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package supervisor_pkg;

  // sequencer states
  typedef enum logic {
    ST_HOLD,
    ST_RUN
  } state_t;

  // reason for the most recent reset
  typedef enum logic [1:0] {
    CAUSE_POR,
    CAUSE_UV,
    CAUSE_MR,
    CAUSE_WDT
  } cause_t;

endpackage : supervisor_pkg

// [src/level_qualifier.sv]
/*
  Two-flop synchroniser followed by a level qualifier: the output takes a
  new level only after the input has shown it for a set number of cycles.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none

module level_qualifier #(
  parameter logic [7:0] ASSERT_CYCLES = 8'h01,
  parameter logic [7:0] RELEASE_CYCLES = 8'h01
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw level, active high
  input wire logic raw_i,
  // qualified level
  output logic level_o
);

  // --------------------------------------------------------------------------
  // synchroniser and stability counter
  // --------------------------------------------------------------------------
  logic sync1_r;
  logic sync2_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic level_nxt;

  // first flop feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= raw_i;
      sync2_r <= sync1_r;
    end
  end

  // separate limits give the hysteresis in time
  wire [7:0] lim = sync2_r ? ASSERT_CYCLES : RELEASE_CYCLES;
  wire differs = (sync2_r != level_o);
  wire reached = differs && (cnt_r >= lim - 8'h01);

  // counter restarts whenever the input agrees with the output
  always_comb begin
    cnt_nxt = 8'h00;
    level_nxt = level_o;
    if (reached) begin
      level_nxt = sync2_r; // [R8]
    end else if (differs) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 8'h00;
      level_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      level_o <= level_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  property p_qual_change;
    @(posedge clk_i) disable iff (rst_i)
      $changed(level_o) |-> level_o == $past(sync2_r);
  endproperty
  a_qual_change: assert property (p_qual_change) // [R8]
    else $error("qualified level took a value the input did not show");

endmodule : level_qualifier

`default_nettype wire

// [src/reset_supervisor.sv]
/*
  Reset supervisor: combines undervoltage flags, a debounced manual reset on
  a shared open-drain pin and a host-kicked watchdog into complementary
  reset outputs, held for a fixed time after every cause clears.
  Assumes the comparator flags are synchronous levels, the shared pin has an
  external pull-up, and SYS_RST_I is the power-up reset.
*/
// Behaviour
// R1: reset on power-up, undervoltage, manual, watchdog
// R2: high output and open-drain low together
// R3: shared pin drives reset, reads debounced manual
// R4: supply low flag always forces reset
// R5: auxiliary low flag always forces reset
// R6: hold reset until voltages good hold period
// R7: power-up reset held through hold period
// R8: qualification hysteresis prevents output chatter
// R9: manual low for 1 us causes reset
// R10: after manual release, hold period then release
// R11: host toggles kick within each normal timeout
// R12: untoggled kick at timeout forces reset
// R13: kick edges and manual reset clear watchdog
// R14: any reset clears the watchdog count
// R15: long startup timeout never forces reset
// R16: capacitor variant selects longer hold duration
// R17: host holds each kick level 100 ns
// R18: synchronised inputs, one tick timebase
// R19: startup timeout ends at first kick or expiry
`timescale 1ns/10ps
`default_nettype none
`include "supervisor_regs.svh"

module reset_supervisor #(
  parameter logic [16:0] TICK_CYCLES = 17'(`TICK_CYCLES),
  parameter logic [15:0] HOLD_TICKS = 16'(`HOLD_TICKS),
  parameter logic [15:0] HOLD_CAP_TICKS = 16'(`HOLD_CAP_TICKS),
  parameter logic [15:0] WDT_TICKS = 16'(`WDT_TICKS),
  parameter logic [15:0] WDT_START_TICKS = 16'(`WDT_START_TICKS)
) (
  // clock and power-up reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // comparator flags, high while below trip level
  input wire logic SUPPLY_LOW_I,
  input wire logic AUX_LOW_I,
  // high on the variant with the hold capacitor pin
  input wire logic HOLD_CAP_SEL_I,
  // watchdog kick from the host
  input wire logic WATCHDOG_KICK_IN_I,
  // shared open-drain reset and manual reset pin
  input wire logic RESET_LOW_MANUAL_PIN_I,
  output logic RESET_LOW_MANUAL_PIN_O,
  output logic RESET_LOW_MANUAL_PIN_OE_O,
  // push-pull reset and status
  output logic RESET_HIGH_O,
  output logic WDT_STARTUP_O,
  output var supervisor_pkg::cause_t LAST_CAUSE_O
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic [16:0] tick_cnt_r;
  logic [15:0] hold_cnt_r;
  logic [15:0] hold_cnt_nxt;
  logic [15:0] wdt_cnt_r;
  logic [15:0] wdt_cnt_nxt;
  logic startup_r;
  logic startup_nxt;
  logic kick_s1_r;
  logic kick_s2_r;
  logic kick_s3_r;
  logic supply_q;
  logic aux_q;
  logic mr_q;
  supervisor_pkg::state_t state_r;
  supervisor_pkg::state_t state_nxt;
  supervisor_pkg::cause_t cause_nxt;

  // --------------------------------------------------------------------------
  // timebase
  // --------------------------------------------------------------------------
  // one divided tick drives every timeout, so all periods share one error
  wire tick = (tick_cnt_r == TICK_CYCLES - 17'h00001); // [R18]

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || tick) begin
      tick_cnt_r <= 17'h00000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h00001;
    end
  end

  // --------------------------------------------------------------------------
  // input qualification
  // --------------------------------------------------------------------------
  // undervoltage asserts fast but releases only after a quiet spell
  level_qualifier #(
    .ASSERT_CYCLES(8'(`UV_ASSERT_CYCLES)),
    .RELEASE_CYCLES(8'(`UV_RELEASE_CYCLES))
  ) u_supply_qual (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .raw_i(SUPPLY_LOW_I), // [R4]
    .level_o(supply_q)
  );

  level_qualifier #(
    .ASSERT_CYCLES(8'(`UV_ASSERT_CYCLES)),
    .RELEASE_CYCLES(8'(`UV_RELEASE_CYCLES))
  ) u_aux_qual (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .raw_i(AUX_LOW_I), // [R5]
    .level_o(aux_q)
  );

  // our own drive would read back as a press and latch reset forever, so the
  // pin is sensed only while released; a held button retriggers after hold
  wire mr_raw = ~RESET_LOW_MANUAL_PIN_I & ~RESET_LOW_MANUAL_PIN_OE_O; // [R3]

  level_qualifier #(
    .ASSERT_CYCLES(8'(`MR_MIN_CYCLES)),
    .RELEASE_CYCLES(8'(`MR_MIN_CYCLES))
  ) u_mr_qual (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .raw_i(mr_raw), // [R9]
    .level_o(mr_q)
  );

  // --------------------------------------------------------------------------
  // kick synchroniser and edge detect
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      kick_s1_r <= 1'b0;
      kick_s2_r <= 1'b0;
      kick_s3_r <= 1'b0;
    end else begin
      kick_s1_r <= WATCHDOG_KICK_IN_I;
      kick_s2_r <= kick_s1_r;
      kick_s3_r <= kick_s2_r;
    end
  end

  // both edges count as a kick
  wire kick_edge = kick_s2_r ^ kick_s3_r; // [R18]

  // --------------------------------------------------------------------------
  // cause decode
  // --------------------------------------------------------------------------
  wire in_hold = (state_r == supervisor_pkg::ST_HOLD);
  wire in_run = (state_r == supervisor_pkg::ST_RUN);
  wire uv_any = supply_q | aux_q; // [R4] [R5]
  wire hold_cause = uv_any | mr_q; // [R6] [R10]
  // hold duration stands for the external capacitor setting
  wire [15:0] hold_lim = HOLD_CAP_SEL_I ? HOLD_CAP_TICKS : HOLD_TICKS; // [R16]
  wire hold_done = tick && (hold_cnt_r >= hold_lim - 16'h0001);
  wire [15:0] wdt_lim = startup_r ? WDT_START_TICKS : WDT_TICKS;
  wire wdt_done = in_run && tick && (wdt_cnt_r >= wdt_lim - 16'h0001);
  // expiry of the startup window never resets
  wire wdt_exp = wdt_done && !startup_r; // [R12] [R15]
  // a stray edge right after reset falls in the hold state and is ignored
  wire startup_end = startup_r && in_run && (kick_edge || wdt_done); // [R19]

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cause_nxt = LAST_CAUSE_O;
    case (state_r)
      supervisor_pkg::ST_RUN: begin
        if (hold_cause || wdt_exp) begin
          state_nxt = supervisor_pkg::ST_HOLD; // [R1]
          if (uv_any) begin
            cause_nxt = supervisor_pkg::CAUSE_UV;
          end else if (mr_q) begin
            cause_nxt = supervisor_pkg::CAUSE_MR;
          end else begin
            cause_nxt = supervisor_pkg::CAUSE_WDT;
          end
        end
      end
      supervisor_pkg::ST_HOLD: begin
        if (!hold_cause && hold_done) begin
          state_nxt = supervisor_pkg::ST_RUN; // [R6] [R7] [R10]
        end
      end
      default: begin
        state_nxt = supervisor_pkg::ST_HOLD;
      end
    endcase
  end

  // hold count restarts while any cause is present
  always_comb begin
    hold_cnt_nxt = hold_cnt_r;
    if (!in_hold || hold_cause) begin
      hold_cnt_nxt = 16'h0000; // [R6]
    end else if (tick) begin
      hold_cnt_nxt = hold_cnt_r + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // watchdog
  // --------------------------------------------------------------------------
  // counts only while running; reset, kicks and presses all clear it
  always_comb begin
    wdt_cnt_nxt = wdt_cnt_r;
    startup_nxt = startup_r;
    if (in_hold || kick_edge || mr_q || wdt_done) begin
      wdt_cnt_nxt = 16'h0000; // [R13] [R14]
    end else if (tick) begin
      wdt_cnt_nxt = wdt_cnt_r + 16'h0001;
    end
    if (startup_end) begin
      startup_nxt = 1'b0; // [R19]
    end
  end

  // --------------------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------------------
  // power-up enters the hold state with the long watchdog window armed
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_r <= supervisor_pkg::ST_HOLD; // [R7]
      hold_cnt_r <= 16'h0000;
      wdt_cnt_r <= 16'h0000;
      startup_r <= 1'b1; // [R15]
    end else begin
      state_r <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      wdt_cnt_r <= wdt_cnt_nxt;
      startup_r <= startup_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // output registers
  // --------------------------------------------------------------------------
  // outputs follow the next state so they switch with the state itself
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      RESET_HIGH_O <= 1'b1; // [R1] [R7]
      RESET_LOW_MANUAL_PIN_OE_O <= 1'b1;
      RESET_LOW_MANUAL_PIN_O <= 1'b0;
      WDT_STARTUP_O <= 1'b1;
      LAST_CAUSE_O <= supervisor_pkg::CAUSE_POR;
    end else begin
      RESET_HIGH_O <= (state_nxt == supervisor_pkg::ST_HOLD); // [R2]
      RESET_LOW_MANUAL_PIN_OE_O <= (state_nxt == supervisor_pkg::ST_HOLD); // [R2] [R3]
      RESET_LOW_MANUAL_PIN_O <= 1'b0; // open drain only ever pulls low
      WDT_STARTUP_O <= startup_nxt;
      LAST_CAUSE_O <= cause_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  property p_pins_match;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (RESET_HIGH_O == RESET_LOW_MANUAL_PIN_OE_O) && !RESET_LOW_MANUAL_PIN_O;
  endproperty
  a_pins_match: assert property (p_pins_match) // [R2]
    else $error("reset outputs disagree");
  property p_supply_reset;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      supply_q |=> RESET_HIGH_O;
  endproperty
  a_supply_reset: assert property (p_supply_reset) // [R4]
    else $error("supply low did not assert reset");
  property p_aux_reset;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      aux_q |=> RESET_HIGH_O && RESET_LOW_MANUAL_PIN_OE_O;
  endproperty
  a_aux_reset: assert property (p_aux_reset) // [R5]
    else $error("auxiliary low did not assert reset");
  property p_hold_release;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      $fell(RESET_HIGH_O) |-> $past(hold_done) && !$past(hold_cause);
  endproperty
  a_hold_release: assert property (p_hold_release) // [R6]
    else $error("reset released before the hold period");
  property p_mr_reset;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      mr_q |=> RESET_HIGH_O;
  endproperty
  a_mr_reset: assert property (p_mr_reset) // [R9]
    else $error("manual reset did not assert reset");
  property p_mr_hold;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      $fell(mr_q) |-> RESET_HIGH_O [*2];
  endproperty
  a_mr_hold: assert property (p_mr_hold) // [R10]
    else $error("reset dropped at manual release");
  property p_wdt_reset;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      wdt_exp && !hold_cause |=> RESET_HIGH_O && LAST_CAUSE_O == supervisor_pkg::CAUSE_WDT;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) // [R12]
    else $error("watchdog expiry did not assert reset");
  property p_kick_clear;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      kick_edge |=> wdt_cnt_r == 16'h0000;
  endproperty
  a_kick_clear: assert property (p_kick_clear) // [R13]
    else $error("kick edge did not clear the watchdog");
  property p_reset_clear;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      in_hold |=> wdt_cnt_r == 16'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [R14]
    else $error("watchdog counted during reset");
  property p_startup_quiet;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      startup_r && in_run && !hold_cause |=> !RESET_HIGH_O;
  endproperty
  a_startup_quiet: assert property (p_startup_quiet) // [R15]
    else $error("reset asserted inside the startup window");
  property p_startup_end;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      startup_r && in_run && kick_edge |=> !startup_r && !WDT_STARTUP_O;
  endproperty
  a_startup_end: assert property (p_startup_end) // [R19]
    else $error("first kick did not end the startup window");

  // --------------------------------------------------------------------------
  // coverage
  // --------------------------------------------------------------------------
  c_wdt_reset: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) wdt_exp);
  c_mr_reset: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) $rose(mr_q));
  c_startup_end: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) $fell(startup_r));
  c_release: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) $fell(RESET_HIGH_O));
endmodule : reset_supervisor

`default_nettype wire

// [dv/host_kicker.sv]
/*
  Host model that kicks the supervisor watchdog by toggling a level.
  Assumes the bench drives en_i and half_i on the falling clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

module host_kicker (
  // clock and control
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [7:0] half_i,
  // kick line to the supervisor
  output logic kick_o
);
  int cnt;

  // --------------------------------------------------------------------------
  // toggle engine
  // --------------------------------------------------------------------------
  initial begin
    kick_o = 1'b0;
    cnt = 0;
  end

  // half_i of 10 or more keeps each level 100 ns; silent when disabled
  always @(negedge clk_i) begin
    if (en_i) begin
      cnt = cnt + 1;
      if (cnt >= int'(half_i)) begin
        cnt = 0;
        kick_o = ~kick_o;
      end
    end else begin
      cnt = 0;
    end
  end
endmodule : host_kicker

`default_nettype wire

// [dv/supply_reset_supervisor_watchdog_tb_top.sv]
/*
  Self-checking bench for the reset supervisor with a kicking host model.
  Assumes short tick and period parameters; pin has a pull-up and a button.
*/
`timescale 1ns/10ps
`default_nettype none

module supply_reset_supervisor_watchdog_tb_top;
  localparam int TC = 4;
  localparam int H = 3;
  localparam int HC = 4;
  localparam int W = 20;
  localparam int S = 30;
  logic clk, rst, sup_low, aux_low, cap_sel, btn, kick_en, run;
  logic [7:0] half;
  wire kick, pin_o, pin_oe, rst_hi, wdt_st, pin_w;
  supervisor_pkg::cause_t cause;
  supervisor_pkg::cause_t exp_q[$];
  int bad_count, samples_checked, n;

  // --------------------------------------------------------------------------
  // structure
  // --------------------------------------------------------------------------
  // open-drain pin with pull-up: low when the supervisor or the button pulls
  assign pin_w = !((pin_oe && !pin_o) || btn);

  reset_supervisor #(.TICK_CYCLES(17'(TC)), .HOLD_TICKS(16'(H)),
    .HOLD_CAP_TICKS(16'(HC)), .WDT_TICKS(16'(W)), .WDT_START_TICKS(16'(S))) DUT (
    .CLK_I(clk), .SYS_RST_I(rst), .SUPPLY_LOW_I(sup_low), .AUX_LOW_I(aux_low),
    .HOLD_CAP_SEL_I(cap_sel), .WATCHDOG_KICK_IN_I(kick),
    .RESET_LOW_MANUAL_PIN_I(pin_w), .RESET_LOW_MANUAL_PIN_O(pin_o),
    .RESET_LOW_MANUAL_PIN_OE_O(pin_oe), .RESET_HIGH_O(rst_hi),
    .WDT_STARTUP_O(wdt_st), .LAST_CAUSE_O(cause));

  host_kicker HOST (.clk_i(clk), .en_i(kick_en), .half_i(half), .kick_o(kick));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // --------------------------------------------------------------------------
  // checking helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // range check: prints the count itself against the low bound
  task automatic rchk(input int v, input int lo, input int hi);
    chk((v >= lo && v <= hi) ? lo : v, lo);
  endtask : rchk

  function automatic logic get(input int sel);
    return (sel == 0) ? rst_hi : ((sel == 1) ? wdt_st : kick);
  endfunction : get

  task automatic test_done();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // bounded wait for a level, n = falling edges taken
  task automatic wt(input int sel, input logic v, input int mx, output int k);
    k = 0;
    while (get(sel) !== v) begin
      @(negedge clk);
      k++;
      if (k > mx) begin
        chk(32'h0, 32'h1);
        test_done();
      end
    end
  endtask : wt

  // level must hold for a number of cycles
  task automatic stay(input int sel, input logic v, input int cyc);
    logic ok;
    ok = 1'b1;
    repeat (cyc) begin
      @(negedge clk);
      ok = ok & (get(sel) === v);
    end
    chk({31'h0, ok}, 32'h1);
  endtask : stay

  // --------------------------------------------------------------------------
  // monitors
  // --------------------------------------------------------------------------
  // both reset outputs move together, pin data is always low
  always @(negedge clk) begin
    if (run) begin
      chk({30'h0, rst_hi, pin_o}, {30'h0, pin_oe, 1'b0});
    end
  end

  // each new reset carries the cause predicted by the scenario
  always @(posedge rst_hi) begin
    if (run) begin
      @(negedge clk);
      chk(32'(cause), 32'(exp_q.pop_front()));
    end
  end

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    sup_low = 1'b0;
    aux_low = 1'b0;
    cap_sel = 1'b0;
    btn = 1'b0;
    kick_en = 1'b0;
    run = 1'b0;
    half = 8'h0C;
    bad_count = 0;
    samples_checked = 0;
    n = $urandom(77);
    repeat (20) @(negedge clk);
    chk({28'h0, rst_hi, pin_oe, pin_o, wdt_st}, 32'h0000000D);
    chk(32'(cause), 32'(supervisor_pkg::CAUSE_POR));
    rst = 1'b0;
    run = 1'b1;
    wt(0, 1'b0, H*TC+8, n);
    rchk(n, (H-1)*TC-1, H*TC+3);
    // no kicks: startup window passes quietly, then the normal one bites
    exp_q.push_back(supervisor_pkg::CAUSE_WDT);
    wt(1, 1'b0, S*TC+8, n);
    rchk(n, (S-1)*TC-1, S*TC+4);
    chk({31'h0, rst_hi}, 32'h0);
    wt(0, 1'b1, W*TC+8, n);
    rchk(n, (W-1)*TC-1, W*TC+4);
    kick_en = 1'b1;
    wt(0, 1'b0, H*TC+8, n);
    rchk(n, (H-1)*TC-1, H*TC+3);
    // random kick spacing, always inside the normal window
    repeat (4) begin
      half = 8'(10 + $urandom % 20);
      stay(0, 1'b0, 3*W*TC);
    end
    // host goes silent right after an edge
    exp_q.push_back(supervisor_pkg::CAUSE_WDT);
    wt(2, !kick, 40, n);
    kick_en = 1'b0;
    wt(0, 1'b1, W*TC+8, n);
    rchk(n, (W-1)*TC, W*TC+5);
    kick_en = 1'b1;
    wt(0, 1'b0, H*TC+8, n);
    // supply dip with a short recovery glitch inside it
    exp_q.push_back(supervisor_pkg::CAUSE_UV);
    sup_low = 1'b1;
    wt(0, 1'b1, 8, n);
    rchk(n, 2, 6);
    sup_low = 1'b0;
    stay(0, 1'b1, 50);
    sup_low = 1'b1;
    repeat (20 + $urandom % 50) @(negedge clk);
    sup_low = 1'b0;
    wt(0, 1'b0, 120+H*TC, n);
    rchk(n, 98+(H-1)*TC, 106+H*TC);
    // aux dip on the capacitor variant: longer hold
    cap_sel = 1'b1;
    exp_q.push_back(supervisor_pkg::CAUSE_UV);
    aux_low = 1'b1;
    wt(0, 1'b1, 8, n);
    rchk(n, 2, 6);
    aux_low = 1'b0;
    wt(0, 1'b0, 120+HC*TC, n);
    rchk(n, 98+(HC-1)*TC, 106+HC*TC);
    cap_sel = 1'b0;
    // short press is filtered, a long one resets
    btn = 1'b1;
    stay(0, 1'b0, 50);
    btn = 1'b0;
    stay(0, 1'b0, 20);
    exp_q.push_back(supervisor_pkg::CAUSE_MR);
    btn = 1'b1;
    wt(0, 1'b1, 120, n);
    rchk(n, 100, 106);
    btn = 1'b0;
    wt(0, 1'b0, 120+H*TC, n);
    rchk(n, 98+(H-1)*TC, 106+H*TC);
    // second power-up mid-run: the first kick ends the startup window early
    exp_q.push_back(supervisor_pkg::CAUSE_POR);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    chk({28'h0, rst_hi, pin_oe, pin_o, wdt_st}, 32'h0000000D);
    rst = 1'b0;
    wt(0, 1'b0, H*TC+8, n);
    rchk(n, (H-1)*TC-1, H*TC+3);
    chk({31'h0, wdt_st}, 32'h1);
    wt(1, 1'b0, 40, n);
    rchk(n, 1, 34);
    chk({31'h0, rst_hi}, 32'h0);
    test_done();
  end
endmodule : supply_reset_supervisor_watchdog_tb_top

`default_nettype wire
